// [hw/phy_port_regs_pkg.sv]
// package: offsets, field positions, reset values and carrier types for the phy port register bank
package phy_port_regs_pkg;

   // register byte offsets
   localparam logic [7:0] P1_STATUS_OFS   = 8'h29;
   localparam logic [7:0] P1_SPECIAL_OFS  = 8'h2a;
   localparam logic [7:0] P1_NEGCTRL_OFS  = 8'h2c;
   localparam logic [7:0] P2_STATUS_OFS   = 8'h39;
   localparam logic [7:0] P2_SPECIAL_OFS  = 8'h3a;
   localparam logic [7:0] P2_NEGCTRL_OFS  = 8'h3c;
   localparam logic [7:0] RMII_CLKCTL_OFS = 8'h57;

   // field positions
   localparam int RMII_CLK_DIS_BIT   = 3;
   localparam int XOVER_SEL_BIT      = 7;
   localparam int POL_REV_BIT        = 5;
   localparam int TX_FC_BIT          = 4;
   localparam int RX_FC_BIT          = 3;
   localparam int SPEED_BIT          = 2;
   localparam int DUPLEX_BIT         = 1;
   localparam int FORCE_LINK_BIT     = 3;
   localparam int PWR_SAVE_BIT       = 2;
   localparam int REMOTE_LOOP_BIT    = 1;
   localparam int AN_DISABLE_BIT     = 7;
   localparam int FORCED_SPEED_BIT   = 6;
   localparam int FORCED_DUPLEX_BIT  = 5;
   localparam int ADV_FC_BIT         = 4;

   // reset values
   localparam logic [7:0] RMII_CLKCTL_RST = 8'h00;
   localparam logic       XOVER_SEL_RST   = 1'h1;
   localparam logic [7:0] SPECIAL_RST     = 8'h00;
   localparam logic [7:0] NEGCTRL_RST     = 8'h5f;
   localparam logic [7:0] ZERO_BYTE       = 8'h00;

   // live link result reported by one phy port
   typedef struct packed {
      logic pol_rev;
      logic tx_fc;
      logic rx_fc;
      logic speed_100;
      logic full_duplex;
   } link_status_t;

   // control outputs steering one phy port
   typedef struct packed {
      logic       crossover_algorithm_select;
      logic       force_link;
      logic       power_save;
      logic       remote_loopback;
      logic       an_disable;
      logic       forced_speed_100;
      logic       forced_full_duplex;
      logic [4:0] advertise;   // fc, 100fd, 100hd, 10fd, 10hd
   } port_ctrl_t;

endpackage

// [hw/phy_port_control_status.sv]
// module: per-port phy control and status register bank with the reduced-mii clock control
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module phy_port_control_status
   import phy_port_regs_pkg::*;
(
   input  wire logic         sys_clk,          // switch clock, 20 MHz
   input  wire logic         srst,             // synchronous reset, active high
   input  wire logic [7:0]   reg_addr,         // register byte address
   input  wire logic [7:0]   reg_wdata,        // write data
   input  wire logic         reg_wr,           // write strobe
   input  wire logic         reg_rd,           // read strobe
   output logic      [7:0]   reg_rdata,        // read data, cycle after strobe
   input  wire link_status_t port1_link_in,    // port 1 live link result, asynchronous
   input  wire link_status_t port2_link_in,    // port 2 live link result, asynchronous
   output port_ctrl_t        port1_ctrl,       // port 1 controls
   output port_ctrl_t        port2_ctrl,       // port 2 controls
   output logic              fourth_mac_refclk_en  // drive 50 MHz clock on receive_clock_pin
);

   ////////////////////////////////////////////////////////////////////////////
   // status synchronisers
   link_status_t p1_meta_q, p1_sync_q, p2_meta_q, p2_sync_q;

   // two flops per status bit before anything reads it
   always_ff @(posedge sys_clk) begin
      p1_meta_q <= port1_link_in;
      p1_sync_q <= p1_meta_q;
      p2_meta_q <= port2_link_in;
      p2_sync_q <= p2_meta_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // control register storage
   logic       rmii_clk_dis_q;
   logic [1:0] xover_q;
   logic [7:0] special_q [2];
   logic [7:0] negctrl_q [2];

   // address decode
   wire wr_clk  = reg_wr && (reg_addr == RMII_CLKCTL_OFS);
   wire wr_st1  = reg_wr && (reg_addr == P1_STATUS_OFS);
   wire wr_st2  = reg_wr && (reg_addr == P2_STATUS_OFS);
   wire wr_sp1  = reg_wr && (reg_addr == P1_SPECIAL_OFS);
   wire wr_sp2  = reg_wr && (reg_addr == P2_SPECIAL_OFS);
   wire wr_ng1  = reg_wr && (reg_addr == P1_NEGCTRL_OFS);
   wire wr_ng2  = reg_wr && (reg_addr == P2_NEGCTRL_OFS);

   // only writable bits of the special register are kept
   localparam logic [7:0] SPECIAL_WMASK = 8'h0e;

   // clock control register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rmii_clk_dis_q <= RMII_CLKCTL_RST[RMII_CLK_DIS_BIT];
      end else if (wr_clk) begin
         rmii_clk_dis_q <= reg_wdata[RMII_CLK_DIS_BIT];
      end
   end

   // crossover selects, the only writable status bit
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         xover_q <= {2{XOVER_SEL_RST}};
      end else begin
         if (wr_st1) xover_q[0] <= reg_wdata[XOVER_SEL_BIT];
         if (wr_st2) xover_q[1] <= reg_wdata[XOVER_SEL_BIT];
      end
   end

   // special control and negotiation control, ports 1 and 2 only
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         special_q[0] <= SPECIAL_RST;
         special_q[1] <= SPECIAL_RST;
         negctrl_q[0] <= NEGCTRL_RST;
         negctrl_q[1] <= NEGCTRL_RST;
      end else begin
         if (wr_sp1) special_q[0] <= reg_wdata & SPECIAL_WMASK;
         if (wr_sp2) special_q[1] <= reg_wdata & SPECIAL_WMASK;
         if (wr_ng1) negctrl_q[0] <= reg_wdata;
         if (wr_ng2) negctrl_q[1] <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read view
   function automatic logic [7:0] status_byte(input logic sel, input link_status_t s);
      logic [7:0] b;
      b = ZERO_BYTE;
      b[XOVER_SEL_BIT] = sel;
      b[POL_REV_BIT]   = s.pol_rev;
      b[TX_FC_BIT]     = s.tx_fc;
      b[RX_FC_BIT]     = s.rx_fc;
      b[SPEED_BIT]     = s.speed_100;
      b[DUPLEX_BIT]    = s.full_duplex;
      return b;
   endfunction

   // read mux; anything unmapped reads zero
   logic [7:0] rd_mux;
   always_comb begin
      case (reg_addr)
         RMII_CLKCTL_OFS: rd_mux = {4'h0, rmii_clk_dis_q, 3'h0};
         P1_STATUS_OFS:   rd_mux = status_byte(xover_q[0], p1_sync_q);
         P2_STATUS_OFS:   rd_mux = status_byte(xover_q[1], p2_sync_q);
         P1_SPECIAL_OFS:  rd_mux = special_q[0];
         P2_SPECIAL_OFS:  rd_mux = special_q[1];
         P1_NEGCTRL_OFS:  rd_mux = negctrl_q[0];
         P2_NEGCTRL_OFS:  rd_mux = negctrl_q[1];
         default:         rd_mux = ZERO_BYTE;
      endcase
   end

   // read data register, held only in the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         reg_rdata <= ZERO_BYTE;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : ZERO_BYTE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control outputs, registered
   function automatic port_ctrl_t make_ctrl(input logic sel, input logic [7:0] sp, input logic [7:0] ng);
      port_ctrl_t c;
      c.crossover_algorithm_select = sel;
      c.force_link         = sp[FORCE_LINK_BIT];
      c.power_save         = sp[PWR_SAVE_BIT];
      c.remote_loopback    = sp[REMOTE_LOOP_BIT];
      c.an_disable         = ng[AN_DISABLE_BIT];
      c.forced_speed_100   = ng[FORCED_SPEED_BIT];
      c.forced_full_duplex = ng[FORCED_DUPLEX_BIT];
      c.advertise          = ng[ADV_FC_BIT:0];
      return c;
   endfunction

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         port1_ctrl           <= make_ctrl(XOVER_SEL_RST, SPECIAL_RST, NEGCTRL_RST);
         port2_ctrl           <= make_ctrl(XOVER_SEL_RST, SPECIAL_RST, NEGCTRL_RST);
         fourth_mac_refclk_en <= 1'b1;
      end else begin
         port1_ctrl           <= make_ctrl(xover_q[0], special_q[0], negctrl_q[0]);
         port2_ctrl           <= make_ctrl(xover_q[1], special_q[1], negctrl_q[1]);
         fourth_mac_refclk_en <= ~rmii_clk_dis_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   a_clk_enable_follows: assert property (@(posedge sys_clk) disable iff (srst)
      wr_clk ##1 1'b1 |=> fourth_mac_refclk_en == !$past(reg_wdata[RMII_CLK_DIS_BIT], 2))
      else $error("reference clock enable wrong after write");
   a_status_polarity: assert property (@(posedge sys_clk) disable iff (srst)
      reg_rd && reg_addr == P1_STATUS_OFS |=> reg_rdata[POL_REV_BIT] == $past(p1_sync_q.pol_rev))
      else $error("polarity bit mismatch");
   a_status_speed: assert property (@(posedge sys_clk) disable iff (srst)
      reg_rd && reg_addr == P2_STATUS_OFS |=> reg_rdata[SPEED_BIT] == $past(p2_sync_q.speed_100)
         && reg_rdata[DUPLEX_BIT] == $past(p2_sync_q.full_duplex))
      else $error("speed or duplex bit mismatch");
   a_status_fc: assert property (@(posedge sys_clk) disable iff (srst)
      reg_rd && reg_addr == P1_STATUS_OFS |=> reg_rdata[TX_FC_BIT] == $past(p1_sync_q.tx_fc)
         && reg_rdata[RX_FC_BIT] == $past(p1_sync_q.rx_fc))
      else $error("flow control bits mismatch");
   a_reserved_zero: assert property (@(posedge sys_clk) disable iff (srst)
      reg_rd && reg_addr == 8'h4a |=> reg_rdata == ZERO_BYTE)
      else $error("reserved offset not zero");
   a_status_reserved: assert property (@(posedge sys_clk) disable iff (srst)
      reg_rd && reg_addr == P1_STATUS_OFS |=> reg_rdata[6] == 1'b0 && reg_rdata[0] == 1'b0)
      else $error("reserved status bit set");
   a_negctrl_loop: assert property (@(posedge sys_clk) disable iff (srst)
      wr_ng1 ##1 !wr_ng1 ##1 1'b1 |-> port1_ctrl.an_disable == $past(reg_wdata[AN_DISABLE_BIT], 2))
      else $error("negotiation disable not applied");
   a_special_readback: assert property (@(posedge sys_clk) disable iff (srst)
      wr_sp2 ##1 reg_rd && reg_addr == P2_SPECIAL_OFS && !reg_wr |=>
         reg_rdata == ($past(reg_wdata, 2) & SPECIAL_WMASK))
      else $error("special control readback wrong");
   a_idle_rdata: assert property (@(posedge sys_clk) disable iff (srst)
      !reg_rd |=> reg_rdata == ZERO_BYTE)
      else $error("read data outside read slot");
   a_xover_readback: assert property (@(posedge sys_clk) disable iff (srst)
      wr_st2 ##1 reg_rd && reg_addr == P2_STATUS_OFS && !reg_wr |=>
         reg_rdata[XOVER_SEL_BIT] == $past(reg_wdata[XOVER_SEL_BIT], 2))
      else $error("crossover select readback wrong");
   a_special_reserved: assert property (@(posedge sys_clk) disable iff (srst)
      reg_rd && reg_addr == P1_SPECIAL_OFS |=> reg_rdata[7:4] == 4'h0 && reg_rdata[0] == 1'b0)
      else $error("reserved special bit set");
   a_clkctl_reserved: assert property (@(posedge sys_clk) disable iff (srst)
      reg_rd && reg_addr == RMII_CLKCTL_OFS |=> reg_rdata[7:4] == 4'h0 && reg_rdata[2:0] == 3'h0)
      else $error("reserved clock control bit set");
   a_force_link_out: assert property (@(posedge sys_clk) disable iff (srst)
      wr_sp1 ##1 1'b1 |=> port1_ctrl.force_link == $past(reg_wdata[FORCE_LINK_BIT], 2))
      else $error("force link output wrong");
   a_advertise_out: assert property (@(posedge sys_clk) disable iff (srst)
      wr_ng2 ##1 1'b1 |=> port2_ctrl.advertise == $past(reg_wdata[ADV_FC_BIT:0], 2))
      else $error("advertise output wrong");
   a_p2_polarity: assert property (@(posedge sys_clk) disable iff (srst)
      reg_rd && reg_addr == P2_STATUS_OFS |=> reg_rdata[POL_REV_BIT] == $past(p2_sync_q.pol_rev))
      else $error("port 2 polarity bit mismatch");

endmodule

// [tb/link_partner_model.sv]
// model: link partner side, presents live link result levels to one port
`timescale 1ns/1ps
module link_partner_model
   import phy_port_regs_pkg::*;
(
   input  wire link_status_t want,   // link result the bench asks for
   output link_status_t      line    // level seen by the port
);
   // results land mid-cycle, unrelated to the switch clock
   always @(want) line <= #13 want;
endmodule

// [tb/tb_top.sv]
// testbench: register bus scenarios with a read-data scoreboard
`timescale 1ns/1ps
module tb_top;
   import phy_port_regs_pkg::*;
   logic         sys_clk, srst, reg_wr, reg_rd, rd_d, clk_dis;
   logic [7:0]   reg_addr, reg_wdata, reg_rdata;
   link_status_t st1, st2, lnk1, lnk2;
   port_ctrl_t   ctrl1, ctrl2;
   logic         refclk_en;
   logic [7:0]   exp_q[$];
   logic         xs[2];
   logic [7:0]   sp[2], nc[2];
   int           mismatches, compares, cycles;
   logic [7:0]   rsv[9] = '{8'h2b, 8'h3b, 8'h49, 8'h4a, 8'h4c, 8'h59, 8'h5a, 8'h5c, 8'h00};

   phy_port_control_status dut_u (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port1_link_in(lnk1), .port2_link_in(lnk2),
      .port1_ctrl(ctrl1), .port2_ctrl(ctrl2), .fourth_mac_refclk_en(refclk_en));
   link_partner_model pm1_u (.want(st1), .line(lnk1));
   link_partner_model pm2_u (.want(st2), .line(lnk2));

   ////////////////////////////////////////////////////////////////////////////////
   // clock and cycle ceiling
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // expected values from the bench's own shadow copies
   function automatic logic [7:0] ofs(int p, int k);
      return (p == 1 ? P2_STATUS_OFS : P1_STATUS_OFS) + 8'(k);
   endfunction
   function automatic logic [7:0] stat(int p);
      return {xs[p], 1'b0, (p == 1 ? st2 : st1), 1'b0};
   endfunction
   function automatic logic [11:0] ctl(int p);
      return {xs[p], sp[p][3:1], nc[p]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // compare tasks and closing report
   task automatic chk_rd(string what, logic [7:0] exp, logic [7:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_ctl(string what, logic [11:0] exp, logic [11:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // bus master tasks, one strobe cycle each for wr and rd; idle waits n cycles, ports checks the control outputs
   task automatic wr(logic [7:0] a, logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      exp_q.push_back(e);
      @(posedge sys_clk);
   endtask
   task automatic idle(int n);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic ports();
      idle(1);
      @(negedge sys_clk);
      chk_ctl("port1_ctrl", ctl(0), ctrl1);
      chk_ctl("port2_ctrl", ctl(1), ctrl2);
      chk_ctl("fourth_mac_refclk_en", {11'h000, ~clk_dis}, {11'h000, refclk_en});
      @(posedge sys_clk);
   endtask

   // read data stand only in the cycle after the strobe
   always @(posedge sys_clk) rd_d <= reg_rd;
   always @(negedge sys_clk) begin
      if (rd_d === 1'b1) begin
         if (exp_q.size() > 0) chk_rd("reg_rdata", exp_q.pop_front(), reg_rdata);
         else begin
            mismatches++;
            $display("MISMATCH reg_rdata expected none seen %h", reg_rdata);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [7:0] d;
      void'($urandom(32'h2d04));
      {srst, reg_wr, reg_rd, reg_addr, reg_wdata, st1, st2} = {1'b1, 28'h000_0000};
      {mismatches, compares, cycles, rd_d, clk_dis} = '0;
      xs = '{XOVER_SEL_RST, XOVER_SEL_RST};
      sp = '{SPECIAL_RST, SPECIAL_RST};
      nc = '{NEGCTRL_RST, NEGCTRL_RST};
      repeat (5) @(posedge sys_clk);
      srst <= 1'b0;
      // reset values of the special, negotiation and clock control registers
      for (int p = 0; p < 2; p++) begin
         rd(ofs(p, 1), SPECIAL_RST);
         rd(ofs(p, 3), NEGCTRL_RST);
      end
      rd(RMII_CLKCTL_OFS, RMII_CLKCTL_RST);
      ports();
      // walking ones then random link results through the synchroniser
      for (int i = 0; i < 9; i++) begin
         st1 <= (i < 5) ? link_status_t'(5'h01 << i) : link_status_t'(5'($urandom));
         st2 <= (i < 5) ? link_status_t'(5'h10 >> i) : link_status_t'(5'($urandom));
         idle(4);
         rd(P1_STATUS_OFS, stat(0));
         rd(P2_STATUS_OFS, stat(1));
      end
      // writes to the status, special and negotiation registers of both ports, back-to-back read back
      for (int i = 0; i < 8; i++) begin
         d = (i < 2) ? 8'hff : 8'($urandom);
         wr(ofs(i % 2, 0), d);
         xs[i % 2] = d[7];
         wr(ofs(i % 2, 1), ~d);
         sp[i % 2] = ~d & 8'h0e;
         wr(ofs(i % 2, 3), d ^ 8'h5a);
         nc[i % 2] = d ^ 8'h5a;
         rd(ofs(i % 2, 0), stat(i % 2));
         rd(ofs(i % 2, 1), sp[i % 2]);
         rd(ofs(i % 2, 3), nc[i % 2]);
         ports();
      end
      // clock output control, reserved bits stay zero
      for (int i = 0; i < 3; i++) begin
         d = (i == 1) ? 8'hf7 : 8'hff;
         wr(RMII_CLKCTL_OFS, d);
         clk_dis = d[3];
         rd(RMII_CLKCTL_OFS, d & 8'h08);
         ports();
      end
      // wholly reserved offsets read zero and ignore writes
      foreach (rsv[i]) begin
         wr(rsv[i], 8'hff);
         rd(rsv[i], ZERO_BYTE);
      end
      ports();
      idle(2);
      end_sim();
   end
endmodule
